// ---- pmi_conv_model.sv ----
// Behavioural converter that answers the core's conversion requests.
`timescale 1ns/1ns
module pmi_conv_model #(
    parameter int DELAY = 5
) (
    input  wire logic                   clk_sys,
    input  wire logic                   resetn,
    input  wire logic                   hold,
    input  wire pmi_pkg::pmi_conv_req_s conv_req,
    output pmi_pkg::pmi_conv_res_s      conv_res
);
    import pmi_pkg::*;
    logic [1:0] chan_r;
    logic       busy_r;
    int         cnt_r;
    // The code bus toggles outside the done cycle so stale values are not trusted.
    always_ff @(posedge clk_sys or negedge resetn)
        if (!resetn)
        begin
            busy_r   <= 1'b0;
            cnt_r    <= 0;
            chan_r   <= 2'h0;
            conv_res <= '0;
        end
        else
        begin
            conv_res.done <= 1'b0;
            conv_res.code <= ~conv_res.code;
            if (conv_req.start)
            begin
                busy_r <= 1'b1;
                cnt_r  <= 0;
                chan_r <= conv_req.chan;
            end
            else if (busy_r)
            begin
                cnt_r <= cnt_r + 1;
                if (cnt_r >= DELAY && !hold)
                begin
                    busy_r        <= 1'b0;
                    conv_res.done <= 1'b1;
                    conv_res.code <= 12'hA53 + 12'h111 * chan_r;
                end
            end
        end
endmodule

// ---- pmi_core.sv ----
// Register access, serial slave and measurement sequencing of the power monitor.
`timescale 1ns/1ns
module pmi_core #(
    parameter int SCAN_CYCLES  = pmi_pkg::SCAN_CH_CYCLES,
    parameter int STUCK_LIMIT  = pmi_pkg::STUCK_CYCLES,
    parameter bit INVERT_SPLIT = 1'b1
) (
    input  wire logic                   clk_sys,
    input  wire logic                   resetn,
    input  wire logic                   scl_in,
    input  wire logic                   split_data_in,
    output logic                        sda_out,
    output logic                        sda_oe,
    output logic                        split_data_out,
    output logic                        split_data_out_oe,
    input  wire logic [1:0]             addr_strap_hi,
    input  wire logic [1:0]             addr_strap_lo,
    input  wire logic                   power_down_input,
    output logic                        shutdown_active,
    output pmi_pkg::pmi_conv_req_s      conv_req,
    input  wire pmi_pkg::pmi_conv_res_s conv_res
);
    import pmi_pkg::*;

    // ------------------------------------------------------------------
    // Input synchronisers and edge detection
    // ------------------------------------------------------------------
    logic [2:0] scl_sync_r;
    logic [2:0] sda_sync_r;
    logic [1:0] pd_sync_r;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            scl_sync_r <= 3'h7;
            sda_sync_r <= 3'h7;
            pd_sync_r  <= 2'h3;
        end
        else
        begin
            scl_sync_r <= {scl_sync_r[1:0], scl_in};
            sda_sync_r <= {sda_sync_r[1:0], split_data_in};
            pd_sync_r  <= {pd_sync_r[0], power_down_input};
        end
    end

    wire scl      = scl_sync_r[1];
    wire sda      = sda_sync_r[1];
    wire scl_rise = scl_sync_r[1] & ~scl_sync_r[2];
    wire scl_fall = ~scl_sync_r[1] & scl_sync_r[2];
    wire start_ev = scl & scl_sync_r[2] & ~sda_sync_r[1] & sda_sync_r[2];
    wire stop_ev  = scl & scl_sync_r[2] & sda_sync_r[1] & ~sda_sync_r[2];
    wire run      = pd_sync_r[1];

    assign shutdown_active = ~run;

    // ------------------------------------------------------------------
    // Address decode from the straps
    // ------------------------------------------------------------------
    logic [3:0] addr_low;

    always_comb
    begin
        case ({addr_strap_hi, addr_strap_lo})
            {STRAP_HIGH, STRAP_LOW}:  addr_low = 4'h7;
            {STRAP_OPEN, STRAP_HIGH}: addr_low = 4'h8;
            {STRAP_HIGH, STRAP_HIGH}: addr_low = 4'h9;
            {STRAP_OPEN, STRAP_OPEN}: addr_low = 4'hA;
            {STRAP_OPEN, STRAP_LOW}:  addr_low = 4'hB;
            {STRAP_LOW, STRAP_HIGH}:  addr_low = 4'hC;
            {STRAP_HIGH, STRAP_OPEN}: addr_low = 4'hD;
            {STRAP_LOW, STRAP_OPEN}:  addr_low = 4'hE;
            default:                  addr_low = 4'hF;
        endcase
    end

    // ------------------------------------------------------------------
    // Register file and serial slave state
    // ------------------------------------------------------------------
    logic [7:0]  regs_r [0:6];
    pmi_state_e  state_r;
    logic [7:0]  shift_r;
    logic [3:0]  bit_cnt_r;
    logic [1:0]  phase_r;
    logic        reading_r;
    logic [2:0]  ptr_r;
    logic [2:0]  xfer_cnt_r;
    logic        ctrl_wr_r;
    logic        drive_low_r;
    logic        snap_go_r;
    logic        snap_arm_r;
    logic [31:0] stuck_cnt_r;

    wire [7:0] ctrl        = regs_r[REG_CTRL];
    wire       snap_en     = ctrl[BIT_SNAP_EN];
    wire       test_mode   = ctrl[BIT_TEST_MODE];
    wire       page_en     = ctrl[BIT_PAGE_EN];
    wire [2:0] ptr_inc     = (ptr_r == REG_LAST) ? REG_FIRST : ptr_r + 3'h1;
    wire       addr_match  = shift_r[7:1] == {ADDR_PREFIX, addr_low};
    wire       mass_match  = (shift_r[7:1] == ADDR_MASS) & ~shift_r[0];
    wire       more_ok     = page_en | (xfer_cnt_r < 3'h2);
    wire       data_wr_ok  = (ptr_r == REG_CTRL) | test_mode;
    wire       stuck_low   = ~scl | ~sda;
    wire       stuck_fire  = ctrl[BIT_STUCK_EN] & (stuck_cnt_r >= 32'(STUCK_LIMIT));
    wire       byte_done   = scl_fall & (bit_cnt_r == 4'h8);

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            stuck_cnt_r <= 32'h0;
        else if (!stuck_low || !ctrl[BIT_STUCK_EN] || stuck_fire)
            stuck_cnt_r <= 32'h0;
        else
            stuck_cnt_r <= stuck_cnt_r + 32'h1;
    end

    // ------------------------------------------------------------------
    // Converter sequencing
    // ------------------------------------------------------------------
    logic [31:0] tick_cnt_r;
    logic [1:0]  scan_ch_r;
    logic        conv_busy_r;
    logic        snap_busy_r;
    logic [1:0]  conv_ch_r;

    wire tick      = tick_cnt_r >= 32'(SCAN_CYCLES - 1);
    wire scan_go   = run & ~snap_en & ~test_mode & tick & ~conv_busy_r;
    wire snap_go   = run & snap_go_r & ~conv_busy_r;
    wire [1:0] ch_sel   = snap_go ? {ctrl[BIT_SNAP_CH1], ctrl[BIT_SNAP_CH0]} : scan_ch_r;
    wire [1:0] ch_next  = (scan_ch_r == CODE_AUX) ? CODE_SENSE : scan_ch_r + 2'h1;
    wire       store    = conv_res.done & conv_busy_r & ~test_mode;
    wire [2:0] res_hi   = {conv_ch_r, 1'b0};
    wire [2:0] res_lo   = {conv_ch_r, 1'b1};
    wire [2:0] busy_reg = {ch_sel, 1'b1};

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            tick_cnt_r  <= 32'h0;
            scan_ch_r   <= CODE_SENSE;
            conv_busy_r <= 1'b0;
            snap_busy_r <= 1'b0;
            conv_ch_r   <= CODE_SENSE;
            conv_req    <= '0;
        end
        else
        begin
            tick_cnt_r    <= tick ? 32'h0 : tick_cnt_r + 32'h1;
            conv_req      <= '0;
            if (scan_go || snap_go)
            begin
                conv_req.start <= 1'b1;
                conv_req.chan  <= ch_sel;
                conv_ch_r      <= ch_sel;
                conv_busy_r    <= 1'b1;
                snap_busy_r    <= snap_go;
                if (scan_go)
                    scan_ch_r <= ch_next;
            end
            else if (conv_res.done)
            begin
                conv_busy_r <= 1'b0;
                snap_busy_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Serial slave and register writes
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < 6; i++)
                regs_r[i] <= 8'h00;
            regs_r[REG_CTRL] <= CTRL_RESET;
            state_r     <= ST_IDLE;
            shift_r     <= 8'h00;
            bit_cnt_r   <= 4'h0;
            phase_r     <= 2'h0;
            reading_r   <= 1'b0;
            ptr_r       <= REG_FIRST;
            xfer_cnt_r  <= 3'h0;
            ctrl_wr_r   <= 1'b0;
            drive_low_r <= 1'b0;
            snap_go_r   <= 1'b0;
            snap_arm_r  <= 1'b1;
        end
        else
        begin
            if (!snap_en)
                snap_arm_r <= 1'b1;
            if (snap_go)
                snap_go_r <= 1'b0;
            if (snap_go)
                regs_r[busy_reg][BUSY_BIT] <= 1'b1;
            if (store)
            begin
                regs_r[res_hi] <= conv_res.code[11:4];
                regs_r[res_lo] <= {conv_res.code[3:0], 4'h0};
            end
            if (stuck_fire)
            begin
                state_r     <= ST_IDLE;
                drive_low_r <= 1'b0;
            end
            else if (stop_ev)
            begin
                state_r     <= ST_IDLE;
                drive_low_r <= 1'b0;
                ptr_r       <= REG_FIRST;
                if (ctrl_wr_r && xfer_cnt_r == 3'h1 && snap_en && snap_arm_r)
                begin
                    snap_go_r  <= 1'b1;
                    snap_arm_r <= 1'b0;
                end
                ctrl_wr_r <= 1'b0;
            end
            else if (start_ev)
            begin
                state_r     <= ST_RX;
                bit_cnt_r   <= 4'h0;
                phase_r     <= 2'h0;
                xfer_cnt_r  <= 3'h0;
                ctrl_wr_r   <= 1'b0;
                drive_low_r <= 1'b0;
            end
            else
            begin
                case (state_r)
                    ST_IDLE:
                    begin
                        drive_low_r <= 1'b0;
                    end
                    ST_RX:
                    begin
                        if (scl_rise)
                        begin
                            shift_r   <= {shift_r[6:0], sda};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end
                        else if (byte_done)
                        begin
                            bit_cnt_r <= 4'h0;
                            state_r   <= ST_RX_ACK;
                            if (phase_r == 2'h0)
                            begin
                                drive_low_r <= addr_match | mass_match;
                                reading_r   <= shift_r[0] & addr_match;
                                phase_r     <= 2'h1;
                                if (!(addr_match || mass_match))
                                    state_r <= ST_IDLE;
                            end
                            else if (phase_r == 2'h1)
                            begin
                                drive_low_r <= 1'b1;
                                ptr_r       <= shift_r[2:0];
                                phase_r     <= 2'h2;
                            end
                            else if (more_ok)
                            begin
                                drive_low_r <= 1'b1;
                                if (data_wr_ok)
                                    regs_r[ptr_r] <= shift_r;
                                ctrl_wr_r  <= ptr_r == REG_CTRL;
                                xfer_cnt_r <= xfer_cnt_r + 3'h1;
                                ptr_r      <= ptr_inc;
                            end
                            else
                                state_r <= ST_IDLE;
                        end
                    end
                    ST_RX_ACK:
                    begin
                        if (scl_fall)
                        begin
                            if (reading_r && phase_r == 2'h1)
                            begin
                                state_r     <= ST_TX;
                                shift_r     <= {regs_r[ptr_r][6:0], 1'b1};
                                drive_low_r <= ~regs_r[ptr_r][7];
                                bit_cnt_r   <= 4'h1;
                            end
                            else
                            begin
                                state_r     <= ST_RX;
                                drive_low_r <= 1'b0;
                            end
                        end
                    end
                    ST_TX:
                    begin
                        if (scl_fall)
                        begin
                            if (bit_cnt_r == 4'h8)
                            begin
                                drive_low_r <= 1'b0;
                                state_r     <= ST_TX_ACK;
                                xfer_cnt_r  <= xfer_cnt_r + 3'h1;
                                ptr_r       <= ptr_inc;
                            end
                            else
                            begin
                                drive_low_r <= ~shift_r[7];
                                shift_r     <= {shift_r[6:0], 1'b1};
                                bit_cnt_r   <= bit_cnt_r + 4'h1;
                            end
                        end
                    end
                    ST_TX_ACK:
                    begin
                        if (scl_rise)
                        begin
                            if (sda || !more_ok)
                                state_r <= ST_IDLE;
                            else
                                state_r <= ST_RX_ACK;
                        end
                    end
                    default:
                    begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------
    assign sda_out           = 1'b0;
    assign sda_oe            = drive_low_r;
    assign split_data_out    = 1'b0;
    assign split_data_out_oe = INVERT_SPLIT ? ~drive_low_r : drive_low_r;

endmodule

// ---- pmi_core_monitor.sv ----
// Concurrent checks on the ports of the power monitor core.
`timescale 1ns/1ns
module pmi_core_monitor
    import pmi_pkg::*;
#(
    parameter int SCAN_CYCLES  = 50,
    parameter int STUCK_LIMIT  = 200,
    parameter bit INVERT_SPLIT = 1'b1
) (
    input wire logic                   clk_sys,
    input wire logic                   resetn,
    input wire logic                   scl_in,
    input wire logic                   split_data_in,
    input wire logic                   sda_out,
    input wire logic                   sda_oe,
    input wire logic                   split_data_out,
    input wire logic                   split_data_out_oe,
    input wire logic [1:0]             addr_strap_hi,
    input wire logic [1:0]             addr_strap_lo,
    input wire logic                   power_down_input,
    input wire logic                   shutdown_active,
    input wire pmi_pkg::pmi_conv_req_s conv_req,
    input wire pmi_pkg::pmi_conv_res_s conv_res
);
    int   stuck_r;
    logic conv_busy_r;
    always_ff @(posedge clk_sys or negedge resetn)
        if (!resetn)
        begin
            stuck_r     <= 0;
            conv_busy_r <= 1'b0;
        end
        else
        begin
            stuck_r     <= (scl_in && split_data_in) ? 0 :
                           (stuck_r < STUCK_LIMIT + 20) ? stuck_r + 1 : stuck_r;
            conv_busy_r <= conv_req.start ? 1'b1 : (conv_res.done ? 1'b0 : conv_busy_r);
        end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    a_shutdown_on: assert property (!power_down_input [*4] |-> shutdown_active)
        else $error("shutdown flag missing");
    a_shutdown_off: assert property (power_down_input [*4] |-> !shutdown_active)
        else $error("shutdown flag stuck");
    a_no_scan_power_down_input: assert property (shutdown_active [*3] |-> !conv_req.start)
        else $error("conversion started in shutdown");
    a_split_inverted: assert property (split_data_out_oe == (INVERT_SPLIT ? !sda_oe : sda_oe))
        else $error("split output not complement");
    a_open_drain: assert property (sda_out == 1'b0 && split_data_out == 1'b0)
        else $error("data output driven high");
    a_oe_scl_low: assert property ($changed(sda_oe) && stuck_r < STUCK_LIMIT |-> !scl_in)
        else $error("data output changed with clock high");
    a_stuck_release: assert property (stuck_r >= STUCK_LIMIT + 10 |-> !sda_oe)
        else $error("stuck bus not released");
    a_one_conv: assert property (conv_req.start |-> !conv_busy_r)
        else $error("start while converter busy");
    a_start_pulse: assert property (conv_req.start |=> !conv_req.start && conv_req.chan != 2'h3)
        else $error("start longer than one cycle");
endmodule
bind pmi_core pmi_core_monitor #(
    .SCAN_CYCLES(SCAN_CYCLES), .STUCK_LIMIT(STUCK_LIMIT), .INVERT_SPLIT(INVERT_SPLIT)
) pmi_core_monitor_inst (
    .clk_sys(clk_sys), .resetn(resetn), .scl_in(scl_in), .split_data_in(split_data_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .split_data_out(split_data_out),
    .split_data_out_oe(split_data_out_oe), .addr_strap_hi(addr_strap_hi),
    .addr_strap_lo(addr_strap_lo), .power_down_input(power_down_input),
    .shutdown_active(shutdown_active), .conv_req(conv_req), .conv_res(conv_res)
);

// ---- pmi_pkg.sv ----
// Package with constants and carrier types of the power monitor register logic.
package pmi_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [2:0] REG_CTRL      = 3'h6;
    localparam logic [2:0] REG_LAST      = 3'h6;
    localparam logic [2:0] REG_FIRST     = 3'h0;
    localparam logic [7:0] CTRL_RESET    = 8'h0C;
    localparam int         BIT_SNAP_EN   = 7;
    localparam int         BIT_SNAP_CH1  = 6;
    localparam int         BIT_SNAP_CH0  = 5;
    localparam int         BIT_TEST_MODE = 4;
    localparam int         BIT_PAGE_EN   = 3;
    localparam int         BIT_STUCK_EN  = 2;
    localparam int         BUSY_BIT      = 3;

    // ------------------------------------------------------------------
    // Snapshot channel codes and converter step sizes
    // ------------------------------------------------------------------
    localparam logic [1:0] CODE_SENSE    = 2'h0;
    localparam logic [1:0] CODE_SUPPLY   = 2'h1;
    localparam logic [1:0] CODE_AUX      = 2'h2;
    localparam int         STEP_SENSE_NV = 20000;
    localparam int         STEP_SUPPLY_UV = 25000;
    localparam int         STEP_AUX_UV   = 500;

    // ------------------------------------------------------------------
    // Addressing
    // ------------------------------------------------------------------
    localparam logic [2:0] ADDR_PREFIX   = 3'h6;
    localparam logic [6:0] ADDR_MASS     = 7'h66;
    localparam logic [1:0] STRAP_LOW     = 2'h0;
    localparam logic [1:0] STRAP_HIGH    = 2'h1;
    localparam logic [1:0] STRAP_OPEN    = 2'h2;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 100;
    localparam int SCAN_PERIOD_NS = 133333333;
    localparam int SCAN_CH_CYCLES = SCAN_PERIOD_NS / 3 / CLK_PERIOD_NS;
    localparam int STUCK_MS       = 33;
    localparam int STUCK_CYCLES   = STUCK_MS * 1000000 / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Converter carriers and serial slave state type
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       start;
        logic [1:0] chan;
    } pmi_conv_req_s;

    typedef struct packed {
        logic        done;
        logic [11:0] code;
    } pmi_conv_res_s;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_RX     = 5'b00010,
        ST_RX_ACK = 5'b00100,
        ST_TX     = 5'b01000,
        ST_TX_ACK = 5'b10000
    } pmi_state_e;

endpackage

// ---- tb.sv ----
// Self-checking bench of the power monitor serial register logic.
`timescale 1ns/1ns
module tb;
    import pmi_pkg::*;
    localparam int         SCAN_CYC = 50;
    localparam int         STUCK_LIM = 200;
    localparam logic [6:0] DEV = 7'h67;
    logic          clk_sys, resetn, scl_in, mst_sda, hold, power_down_input;
    logic          sda_out, sda_oe, split_data_out, split_data_out_oe, shutdown_active;
    pmi_conv_req_s conv_req;
    pmi_conv_res_s conv_res;
    wire           split_data_in = mst_sda & split_data_out_oe;
    int            n_mismatch, checks;
    logic [1:0]    log_ch[$];
    time           log_t[$];
    pmi_core #(.SCAN_CYCLES(SCAN_CYC), .STUCK_LIMIT(STUCK_LIM), .INVERT_SPLIT(1'b1)) pmi_core_inst (
        .clk_sys(clk_sys), .resetn(resetn), .scl_in(scl_in), .split_data_in(split_data_in),
        .sda_out(sda_out), .sda_oe(sda_oe), .split_data_out(split_data_out),
        .split_data_out_oe(split_data_out_oe), .addr_strap_hi(STRAP_HIGH),
        .addr_strap_lo(STRAP_LOW), .power_down_input(power_down_input),
        .shutdown_active(shutdown_active), .conv_req(conv_req), .conv_res(conv_res));
    pmi_conv_model #(.DELAY(5)) pmi_conv_model_inst (.clk_sys(clk_sys), .resetn(resetn),
        .hold(hold), .conv_req(conv_req), .conv_res(conv_res));
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
        if (conv_req.start === 1'b1)
        begin
            log_ch.push_back(conv_req.chan);
            log_t.push_back($time);
        end
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] hi(input int ch);
        logic [11:0] c;
        c = 12'hA53 + 12'h111 * ch;
        return c[11:4];
    endfunction
    function automatic logic [7:0] lo(input int ch);
        logic [11:0] c;
        c = 12'hA53 + 12'h111 * ch;
        return {c[3:0], 4'h0};
    endfunction
    task automatic clk_n(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask
    task automatic chk_num(input longint got, input longint exp);
        checks++;
        if (got != exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: count %0d, expected %0d", $time, got, exp);
        end
    endtask
    task automatic sbit(input logic b);
        scl_in = 1'b0;
        clk_n(1);
        mst_sda = b;
        clk_n(5);
        scl_in = 1'b1;
        clk_n(4);
    endtask
    task automatic rbit(output logic b);
        scl_in = 1'b0;
        mst_sda = 1'b1;
        clk_n(6);
        scl_in = 1'b1;
        clk_n(2);
        b = split_data_in;
        clk_n(2);
    endtask
    task automatic cond(input logic first);
        scl_in = 1'b0;
        clk_n(3);
        mst_sda = first;
        clk_n(3);
        scl_in = 1'b1;
        clk_n(4);
        mst_sda = ~first;
        clk_n(4);
    endtask
    task automatic send(input logic [7:0] d, input logic exp_ack);
        logic a;
        for (int i = 7; i >= 0; i--)
            sbit(d[i]);
        rbit(a);
        chk_bit(a, ~exp_ack);
    endtask
    task automatic rd_chk(input logic [7:0] cmd, input bit use_cmd, input logic [7:0] exp[$]);
        logic [7:0] d;
        cond(1'b1);
        if (use_cmd)
        begin
            send({DEV, 1'b0}, 1'b1);
            send(cmd, 1'b1);
            cond(1'b1);
        end
        send({DEV, 1'b1}, 1'b1);
        foreach (exp[i])
        begin
            for (int b = 7; b >= 0; b--)
                rbit(d[b]);
            sbit(i == exp.size() - 1);
            chk_byte(d, exp[i]);
        end
        cond(1'b0);
    endtask
    task automatic wr(input logic [7:0] cmd, input logic [7:0] data[$]);
        cond(1'b1);
        send({DEV, 1'b0}, 1'b1);
        send(cmd, 1'b1);
        foreach (data[i])
            send(data[i], 1'b1);
        cond(1'b0);
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_scan();
        rd_chk(8'hF6, 1, {8'h0C});
        for (int i = 0; i < 3; i++)
            chk_byte({6'h00, log_ch[i]}, i[7:0]);
        chk_num(log_t[3] - log_t[0], 3 * SCAN_CYC * 100);
        rd_chk(8'h00, 1, {hi(0), lo(0), hi(1), lo(1), hi(2), lo(2)});
        rd_chk(8'h05, 1, {lo(2), 8'h0C, hi(0)});
        rd_chk(8'h00, 0, {hi(0)});
    endtask
    task automatic t_test_snap();
        int n;
        wr(8'h06, {8'h1C});
        wr(8'h02, {8'h12, 8'h34});
        n = log_ch.size();
        clk_n(4 * SCAN_CYC);
        rd_chk(8'h02, 1, {8'h12, 8'h34});
        chk_num(log_ch.size(), n);
        hold = 1'b1;
        wr(8'h06, {8'hAC});
        clk_n(10);
        chk_num(log_ch.size(), n + 1);
        chk_byte({6'h00, log_ch[$]}, {6'h00, CODE_SUPPLY});
        rd_chk(8'h03, 1, {8'h34 | 8'(1 << BUSY_BIT)});
        hold = 1'b0;
        clk_n(20);
        rd_chk(8'h02, 1, {hi(1), lo(1)});
        wr(8'h06, {8'hAC});
        clk_n(4 * SCAN_CYC);
        chk_num(log_ch.size(), n + 1);
        wr(8'h06, {8'h04});
        rd_chk(8'h00, 1, {hi(0), lo(0), 8'hFF});
        wr(8'h06, {8'h0C});
    endtask
    task automatic t_misc();
        int n;
        cond(1'b1);
        send({7'h68, 1'b0}, 1'b0);
        cond(1'b0);
        power_down_input = 1'b0;
        clk_n(10);
        chk_bit(shutdown_active, 1'b1);
        n = log_ch.size();
        clk_n(3 * SCAN_CYC);
        chk_num(log_ch.size(), n);
        power_down_input = 1'b1;
        clk_n(10);
        chk_bit(shutdown_active, 1'b0);
        cond(1'b1);
        send({DEV, 1'b0}, 1'b1);
        clk_n(STUCK_LIM + 30);
        chk_bit(sda_oe, 1'b0);
        cond(1'b0);
        rd_chk(8'h06, 1, {8'h0C});
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        resetn = 1'b0;
        scl_in = 1'b1;
        mst_sda = 1'b1;
        hold = 1'b0;
        power_down_input = 1'b1;
        n_mismatch = 0;
        checks = 0;
        clk_n(20);
        resetn = 1'b1;
        clk_n(5);
        t_scan();
        t_test_snap();
        t_misc();
        give_verdict();
    end
    initial
    begin
        clk_n(80000);
        n_mismatch++;
        $display("unexpected at %0t: watchdog expired", $time);
        give_verdict();
    end
endmodule
